// *** usi_top.sv ***
// Front-panel indicator logic with status registers and interrupt
//
// Behaviour
// - Run lamp on unless hardware fault or host flag fault set
// - Unit fault lamp follows unit error
// - Controller fault lamp follows host error
// - Network fault lamp pattern per error code
// - Link lamp dark without physical link
// - Link lamp steady with link, no traffic
// - Link lamp flickers during frame traffic
//
// Chosen here: the register offsets and the address-and-strobe port.
module usi_top
	import usi_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES
)
(
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        resetn_in,
	// Internal status sources
	input  wire logic        hw_fault_in,
	input  wire logic        host_flag_fault_in,
	input  wire logic        unit_err_in,
	input  wire logic        host_ctrl_err_in,
	input  wire logic [1:0]  net_state_in,
	input  wire logic [2:0]  net_err_code_in,
	// Physical layer pins
	input  wire logic        phy_link_in,
	input  wire logic        phy_activity_in,
	// Register port
	input  wire logic [3:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [31:0] reg_rdata_out,
	// Interrupt
	output logic             irq_out,
	// Lamps
	output logic             run_lamp_out,
	output logic             unit_fault_lamp_out,
	output logic             controller_fault_lamp_out,
	output logic             network_state_lamp_out,
	output logic             network_fault_lamp_out,
	output logic             link_activity_lamp_out
);

	localparam int TW = $clog2(TICK_CYC + 1);

	logic [TW-1:0]       tick_cnt_q;
	logic                tick_q;
	logic [4:0]          phase_q;
	logic                blink_q;
	logic                single_q;
	logic                double_q;
	logic                flicker_q;
	logic [1:0]          link_sync_q;
	logic [1:0]          act_sync_q;
	logic                link_prev_q;
	logic [1:0]          act_hold_q;
	logic                act_hold;
	logic                unit_prev_q;
	logic                ctrl_prev_q;
	logic [2:0]          err_prev_q;
	logic [1:0]          ctrl_q;
	logic [EV_COUNT-1:0] status_q;
	logic [EV_COUNT-1:0] status_set;
	logic [EV_COUNT-1:0] mask_q;
	logic [31:0]         rdata_q;
	logic                irq_q;
	logic                lamp_test;
	logic                act_en;
	usi_lamp_e           run_mode;
	usi_lamp_e           unit_mode;
	usi_lamp_e           ctrl_mode;
	usi_lamp_e           state_mode;
	usi_lamp_e           err_mode;
	usi_lamp_e           link_mode;

	assign lamp_test = ctrl_q[CTRL_TEST_BIT];
	assign act_en    = ctrl_q[CTRL_ACT_EN_BIT];
	assign act_hold  = (act_hold_q != 2'h0);

	// Base tick divider; every pattern is built from whole ticks
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end
		else if (tick_cnt_q == TW'(TICK_CYC - 1))
		begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b1;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
			tick_q     <= 1'b0;
		end
	end

	// Pattern phases shared by all lamps so they flash in step
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			phase_q   <= 5'h00;
			flicker_q <= 1'b0;
		end
		else if (tick_q)
		begin
			phase_q   <= (phase_q == 5'(FRAME_TICKS - 1)) ? 5'h00 : phase_q + 5'h01;
			flicker_q <= ~flicker_q;
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			blink_q  <= 1'b0;
			single_q <= 1'b0;
			double_q <= 1'b0;
		end
		else
		begin
			blink_q  <= ((phase_q / 5'(ON_TICKS)) % 5'h02) == 5'h00;
			single_q <= phase_q < 5'(ON_TICKS);
			double_q <= (phase_q < 5'(ON_TICKS)) ||
				((phase_q >= 5'(SECOND_ON_TICK)) &&
				(phase_q < 5'(SECOND_ON_TICK + ON_TICKS)));
		end
	end

	// Pins come from the PHY clock domain: two flops before use
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			link_sync_q <= 2'h0;
			act_sync_q  <= 2'h0;
		end
		else
		begin
			link_sync_q <= {link_sync_q[0], phy_link_in};
			act_sync_q  <= {act_sync_q[0], phy_activity_in};
		end
	end

	// Stretch short traffic bursts so the flicker stays visible
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			act_hold_q <= 2'h0;
		end
		else if (!link_sync_q[1])
		begin
			act_hold_q <= 2'h0;
		end
		else if (act_sync_q[1])
		begin
			act_hold_q <= 2'(ACT_HOLD_TICKS);
		end
		else if (tick_q && act_hold)
		begin
			act_hold_q <= act_hold_q - 2'h1;
		end
	end

	// Lamp modes; lamp test forces every lamp on
	always_comb
	begin
		run_mode   = (hw_fault_in || host_flag_fault_in) ? LAMP_OFF : LAMP_ON;
		unit_mode  = unit_err_in ? LAMP_ON : LAMP_OFF;
		ctrl_mode  = host_ctrl_err_in ? LAMP_ON : LAMP_OFF;
		state_mode = LAMP_OFF;
		err_mode   = LAMP_OFF;
		link_mode  = LAMP_OFF;
		unique case (net_state_in)
			NET_ST_INIT:   state_mode = LAMP_OFF;
			NET_ST_PREOP:  state_mode = LAMP_BLINK;
			NET_ST_SAFEOP: state_mode = LAMP_SINGLE;
			NET_ST_OP:     state_mode = LAMP_ON;
		endcase
		// Codes outside the table show steady to err on the visible side
		case (net_err_code_in)
			NET_ERR_NONE:    err_mode = LAMP_OFF;
			NET_ERR_SETTING: err_mode = LAMP_BLINK;
			NET_ERR_SYNC:    err_mode = LAMP_SINGLE;
			NET_ERR_APP_WDT: err_mode = LAMP_DOUBLE;
			NET_ERR_BOOT:    err_mode = LAMP_FLICKER;
			default:         err_mode = LAMP_ON;
		endcase
		if (link_sync_q[1])
		begin
			link_mode = (act_hold && act_en) ? LAMP_FLICKER : LAMP_ON;
		end
		if (lamp_test)
		begin
			run_mode   = LAMP_ON;
			unit_mode  = LAMP_ON;
			ctrl_mode  = LAMP_ON;
			state_mode = LAMP_ON;
			err_mode   = LAMP_ON;
			link_mode  = LAMP_ON;
		end
	end

	usi_lamp u_run (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .mode_in(run_mode),
		.blink_in(blink_q), .single_in(single_q), .double_in(double_q),
		.flicker_in(flicker_q), .lamp_out(run_lamp_out));
	usi_lamp u_unit (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .mode_in(unit_mode),
		.blink_in(blink_q), .single_in(single_q), .double_in(double_q),
		.flicker_in(flicker_q), .lamp_out(unit_fault_lamp_out));
	usi_lamp u_ctrl (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .mode_in(ctrl_mode),
		.blink_in(blink_q), .single_in(single_q), .double_in(double_q),
		.flicker_in(flicker_q), .lamp_out(controller_fault_lamp_out));
	usi_lamp u_state (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .mode_in(state_mode),
		.blink_in(blink_q), .single_in(single_q), .double_in(double_q),
		.flicker_in(flicker_q), .lamp_out(network_state_lamp_out));
	usi_lamp u_err (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .mode_in(err_mode),
		.blink_in(blink_q), .single_in(single_q), .double_in(double_q),
		.flicker_in(flicker_q), .lamp_out(network_fault_lamp_out));
	usi_lamp u_link (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .mode_in(link_mode),
		.blink_in(blink_q), .single_in(single_q), .double_in(double_q),
		.flicker_in(flicker_q), .lamp_out(link_activity_lamp_out));

	// Event edge detection
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			unit_prev_q <= 1'b0;
			ctrl_prev_q <= 1'b0;
			err_prev_q  <= NET_ERR_NONE;
			link_prev_q <= 1'b0;
		end
		else
		begin
			unit_prev_q <= unit_err_in;
			ctrl_prev_q <= host_ctrl_err_in;
			err_prev_q  <= net_err_code_in;
			link_prev_q <= link_sync_q[1];
		end
	end

	always_comb
	begin
		status_set              = '0;
		status_set[EV_UNIT_ERR] = unit_err_in && !unit_prev_q;
		status_set[EV_CTRL_ERR] = host_ctrl_err_in && !ctrl_prev_q;
		status_set[EV_NET_ERR]  = (net_err_code_in != NET_ERR_NONE) &&
			(net_err_code_in != err_prev_q);
		status_set[EV_LINK_UP]  = link_sync_q[1] && !link_prev_q;
		status_set[EV_LINK_DN]  = !link_sync_q[1] && link_prev_q;
	end

	// Sticky status: a new event wins over a write-one clear
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			status_q <= '0;
		end
		else if (reg_wr_in && (reg_addr_in == REG_STATUS))
		begin
			status_q <= (status_q & ~reg_wdata_in[EV_COUNT-1:0]) | status_set;
		end
		else
		begin
			status_q <= status_q | status_set;
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ctrl_q <= CTRL_RESET;
			mask_q <= MASK_RESET;
		end
		else if (reg_wr_in)
		begin
			if (reg_addr_in == REG_CTRL)
			begin
				ctrl_q <= reg_wdata_in[1:0];
			end
			if (reg_addr_in == REG_MASK)
			begin
				mask_q <= reg_wdata_in[EV_COUNT-1:0];
			end
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rdata_q <= 32'h0000_0000;
		end
		else if (reg_rd_in)
		begin
			case (reg_addr_in)
				REG_CTRL:   rdata_q <= {30'h0, ctrl_q};
				REG_STATUS: rdata_q <= {27'h0, status_q};
				REG_MASK:   rdata_q <= {27'h0, mask_q};
				REG_STATE:  rdata_q <= {19'h0, net_err_code_in, net_state_in,
					link_sync_q[1], act_hold, network_fault_lamp_out,
					network_state_lamp_out, link_activity_lamp_out,
					controller_fault_lamp_out, unit_fault_lamp_out, run_lamp_out};
				default:    rdata_q <= 32'h0000_0000;
			endcase
		end
		else
		begin
			rdata_q <= 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			irq_q <= 1'b0;
		end
		else
		begin
			irq_q <= |(status_q & mask_q);
		end
	end

	assign reg_rdata_out = rdata_q;
	assign irq_out       = irq_q;

	a_run_lamp_dark: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		(hw_fault_in || host_flag_fault_in) && !lamp_test |=> !run_lamp_out)
		else $error("run lamp lit during a fault");
	a_run_lamp_lit: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		!hw_fault_in && !host_flag_fault_in && !lamp_test |=> run_lamp_out)
		else $error("run lamp dark in normal operation");
	a_unit_lamp_track: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		!lamp_test ##1 !$past(lamp_test) |-> unit_fault_lamp_out == $past(unit_err_in))
		else $error("unit fault lamp does not follow unit error");
	a_ctrl_lamp_track: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		$rose(host_ctrl_err_in) && !lamp_test |=> controller_fault_lamp_out)
		else $error("controller fault lamp missed host error");
	a_net_err_pdi: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		(net_err_code_in == NET_ERR_PDI_WDT) && !lamp_test |=> network_fault_lamp_out)
		else $error("network fault lamp not steady on interface watchdog");
	a_net_err_boot: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		(net_err_code_in == NET_ERR_BOOT) && !lamp_test
		|=> network_fault_lamp_out == $past(flicker_q))
		else $error("network fault lamp not flickering on boot error");
	a_link_dark: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		!link_sync_q[1] && !lamp_test |=> !link_activity_lamp_out)
		else $error("link lamp lit without link");
	a_link_steady: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		link_sync_q[1] && !act_hold && !lamp_test |=> link_activity_lamp_out)
		else $error("link lamp not steady on idle link");
	a_link_flicker: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		link_sync_q[1] && act_hold && act_en && !lamp_test
		|=> link_activity_lamp_out == $past(flicker_q))
		else $error("link lamp not flickering with traffic");
	a_state_lamp_op: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		(net_state_in == NET_ST_INIT) && !lamp_test ##1 (net_state_in == NET_ST_OP) && !lamp_test
		|-> !network_state_lamp_out ##1 network_state_lamp_out)
		else $error("network state lamp wrong for init or operational");

endmodule

// *** usi_pkg.sv ***
// Shared constants and types for the front-panel status indicator logic
package usi_pkg;

	// Clock and pattern timing
	localparam int CLK_HZ         = 40_000_000;
	localparam int TICK_MS        = 50;
	localparam int TICK_CYCLES    = (CLK_HZ / 1000) * TICK_MS;
	localparam int FRAME_TICKS    = 24;
	localparam int ON_TICKS       = 4;
	localparam int SECOND_ON_TICK = 8;
	localparam int ACT_HOLD_TICKS = 2;

	// Register byte offsets
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_MASK   = 4'h8;
	localparam logic [3:0] REG_STATE  = 4'hc;

	// Control fields and reset values
	localparam int         CTRL_TEST_BIT   = 0;
	localparam int         CTRL_ACT_EN_BIT = 1;
	localparam logic [1:0] CTRL_RESET      = 2'h2;
	localparam logic [4:0] MASK_RESET      = 5'h00;

	// Event bits in status and mask
	localparam int EV_UNIT_ERR = 0;
	localparam int EV_CTRL_ERR = 1;
	localparam int EV_NET_ERR  = 2;
	localparam int EV_LINK_UP  = 3;
	localparam int EV_LINK_DN  = 4;
	localparam int EV_COUNT    = 5;

	// Fieldbus state machine codes
	localparam logic [1:0] NET_ST_INIT   = 2'h0;
	localparam logic [1:0] NET_ST_PREOP  = 2'h1;
	localparam logic [1:0] NET_ST_SAFEOP = 2'h2;
	localparam logic [1:0] NET_ST_OP     = 2'h3;

	// Fieldbus error codes
	localparam logic [2:0] NET_ERR_NONE    = 3'h0;
	localparam logic [2:0] NET_ERR_SETTING = 3'h1;
	localparam logic [2:0] NET_ERR_SYNC    = 3'h2;
	localparam logic [2:0] NET_ERR_APP_WDT = 3'h3;
	localparam logic [2:0] NET_ERR_BOOT    = 3'h4;
	localparam logic [2:0] NET_ERR_PDI_WDT = 3'h5;

	typedef enum logic [2:0] {
		LAMP_OFF,
		LAMP_ON,
		LAMP_BLINK,
		LAMP_SINGLE,
		LAMP_DOUBLE,
		LAMP_FLICKER
	} usi_lamp_e;

endpackage

// *** usi_lamp.sv ***
// One indicator lamp driver: picks a pattern by mode and registers it
module usi_lamp
	import usi_pkg::*;
(
	// Clock and reset
	input  wire logic      core_clk_in,
	input  wire logic      resetn_in,
	// Mode and shared pattern phases
	input  wire usi_lamp_e mode_in,
	input  wire logic      blink_in,
	input  wire logic      single_in,
	input  wire logic      double_in,
	input  wire logic      flicker_in,
	// Lamp drive
	output logic           lamp_out
);

	logic lamp_q;

	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			lamp_q <= 1'b0;
		end
		else
		begin
			unique case (mode_in)
				LAMP_OFF:     lamp_q <= 1'b0;
				LAMP_ON:      lamp_q <= 1'b1;
				LAMP_BLINK:   lamp_q <= blink_in;
				LAMP_SINGLE:  lamp_q <= single_in;
				LAMP_DOUBLE:  lamp_q <= double_in;
				LAMP_FLICKER: lamp_q <= flicker_in;
				default:      lamp_q <= 1'b0;
			endcase
		end
	end

	assign lamp_out = lamp_q;

endmodule

// *** usi_phy_model.sv ***
// Physical layer model: link level and periodic frame traffic strobes
module usi_phy_model
(
	// Clock and commands
	input  wire logic core_clk_in,
	input  wire logic link_cmd_in,
	input  wire logic traffic_cmd_in,
	// Pins towards the indicator logic
	output logic      phy_link_out = 1'b0,
	output logic      phy_activity_out = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] gap_q = 2'h0;
	// One frame every third cycle, and none without a link
	always_ff @(posedge core_clk_in)
	begin
		gap_q <= (gap_q == 2'h2) ? 2'h0 : gap_q + 2'h1;
		phy_link_out <= link_cmd_in;
		phy_activity_out <= link_cmd_in && traffic_cmd_in && (gap_q == 2'h0);
	end
endmodule

// *** tb.sv ***
// Self-checking testbench for the front-panel indicator logic
module tb
	import usi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TC = 4;
	localparam int FR = TC * FRAME_TICKS;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        hw = 1'b0, flag = 1'b0, uerr = 1'b0, cerr = 1'b0;
	logic [1:0]  nst = NET_ST_OP;
	logic [2:0]  nerr = NET_ERR_NONE;
	logic        link_cmd = 1'b0, traf = 1'b0, phy_link, phy_act;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic        wr = 1'b0, rd = 1'b0, rd_d = 1'b0, look = 1'b0, irq;
	logic [5:0]  lamps;
	logic [2:0]  msel = 3'h0;
	logic        prev = 1'b0;
	logic [31:0] q[$];
	int          mcnt = 0, on_n = 0, tr_n = 0, errors = 0, check_count = 0;
	usi_lamp_e   st_m[4] = '{LAMP_OFF, LAMP_BLINK, LAMP_SINGLE, LAMP_ON};
	// Undefined error codes 6 and 7 are shown steady
	usi_lamp_e   er_m[8] = '{LAMP_OFF, LAMP_BLINK, LAMP_SINGLE, LAMP_DOUBLE, LAMP_FLICKER,
		LAMP_ON, LAMP_ON, LAMP_ON};
	always #12.5 clk = ~clk;
	usi_phy_model phy (.core_clk_in(clk), .link_cmd_in(link_cmd), .traffic_cmd_in(traf),
		.phy_link_out(phy_link), .phy_activity_out(phy_act));
	usi_top #(.TICK_CYC(TC)) uut (.core_clk_in(clk), .resetn_in(rstn), .hw_fault_in(hw),
		.host_flag_fault_in(flag), .unit_err_in(uerr), .host_ctrl_err_in(cerr),
		.net_state_in(nst), .net_err_code_in(nerr), .phy_link_in(phy_link),
		.phy_activity_in(phy_act), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq),
		.run_lamp_out(lamps[0]), .unit_fault_lamp_out(lamps[1]),
		.controller_fault_lamp_out(lamps[2]), .network_state_lamp_out(lamps[3]),
		.network_fault_lamp_out(lamps[4]), .link_activity_lamp_out(lamps[5]));
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("Checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		q.push_back(exp);
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task automatic look_at(input logic [6:0] exp);
		@(posedge clk);
		q.push_back({25'h0, exp});
		look <= 1'b1;
		@(posedge clk);
		look <= 1'b0;
	endtask
	// Counts lit cycles and toggles over one whole frame, so the phase does not matter
	function automatic logic [31:0] pat(input usi_lamp_e m);
		case (m)
			LAMP_ON:      pat = {16'(FR), 16'h0};
			LAMP_BLINK:   pat = {16'(FR / 2), 16'(FRAME_TICKS / ON_TICKS)};
			LAMP_SINGLE:  pat = {16'(ON_TICKS * TC), 16'h2};
			LAMP_DOUBLE:  pat = {16'(2 * ON_TICKS * TC), 16'h4};
			LAMP_FLICKER: pat = {16'(FR / 2), 16'(FRAME_TICKS)};
			default:      pat = 32'h0;
		endcase
	endfunction
	task automatic measure(input logic [2:0] s, input usi_lamp_e m);
		repeat (24) @(posedge clk);
		msel <= s;
		mcnt <= FR + 1;
		q.push_back(pat(m));
		repeat (FR + 3) @(posedge clk);
	endtask
	// Watcher: takes the oldest note whenever a result shows up
	always @(posedge clk)
	begin
		rd_d <= rd;
		if (rd_d)
			check("read data", rdata, q.pop_front());
		if (look)
			check("lamps", {25'h0, irq, lamps}, q.pop_front());
		if (mcnt != 0)
		begin
			if (mcnt == FR + 1)
			begin
				on_n = 0;
				tr_n = 0;
			end
			else
			begin
				on_n += int'(prev);
				tr_n += int'(lamps[msel] != prev);
			end
			prev = lamps[msel];
			mcnt <= mcnt - 1;
			if (mcnt == 1)
				check("pattern", {16'(on_n), 16'(tr_n)}, q.pop_front());
		end
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		final_report();
	end
	initial
	begin
		logic [3:0] r;
		void'($urandom(6739));
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rd_reg(REG_CTRL, 32'(CTRL_RESET));
		rd_reg(REG_MASK, 32'(MASK_RESET));
		rd_reg(REG_STATUS, 32'h0);
		rd_reg(4'h1, 32'h0);
		$display("Test reset values done");
		repeat (12)
		begin
			r = 4'($urandom);
			@(posedge clk);
			{hw, flag, uerr, cerr} <= r;
			look_at({3'h1, r[0], r[1], ~(r[3] | r[2])});
		end
		{hw, flag, uerr, cerr} <= 4'h0;
		$display("Test steady lamps done");
		for (int s = 0; s < 4; s++)
		begin
			nst <= 2'(s);
			measure(3'h3, st_m[s]);
		end
		// A jump from init straight to operational
		nst <= NET_ST_INIT;
		repeat (3) @(posedge clk);
		nst <= NET_ST_OP;
		look_at(7'h09);
		$display("Test network state done");
		for (int e = 0; e < 8; e++)
		begin
			nerr <= 3'(e);
			measure(3'h4, er_m[e]);
		end
		nerr <= NET_ERR_NONE;
		$display("Test network fault done");
		measure(3'h5, LAMP_OFF);
		link_cmd <= 1'b1;
		measure(3'h5, LAMP_ON);
		traf <= 1'b1;
		measure(3'h5, LAMP_FLICKER);
		wr_reg(REG_CTRL, 32'h0);
		measure(3'h5, LAMP_ON);
		wr_reg(REG_CTRL, 32'h3);
		look_at(7'h3f);
		wr_reg(REG_CTRL, 32'(CTRL_RESET));
		{link_cmd, traf} <= 2'h0;
		$display("Test link lamp done");
		repeat (8) @(posedge clk);
		wr_reg(REG_STATUS, 32'h1f);
		rd_reg(REG_STATUS, 32'h0);
		uerr <= 1'b1;
		repeat (4) @(posedge clk);
		rd_reg(REG_STATUS, 32'h1);
		wr_reg(REG_MASK, 32'h1);
		look_at(7'h4b);
		wr_reg(REG_MASK, 32'h1e);
		look_at(7'h0b);
		rd_reg(REG_MASK, 32'h1e);
		uerr <= 1'b0;
		wr_reg(REG_STATUS, 32'h1);
		rd_reg(REG_STATUS, 32'h0);
		// Idle snapshot: operational state, run and state lamps lit
		rd_reg(REG_STATE, 32'h0000_0311);
		$display("Test interrupt done");
		repeat (4) @(posedge clk);
		final_report();
	end
endmodule
